// File: core/sau_pkg.sv
// package: opcodes, register map, field positions and carriers for the scalar unary alu
package sau_pkg;

  // ---------------------------------------------------------------
  // datapath widths and constants
  // ---------------------------------------------------------------
  localparam int          SAU_OP_W     = 6;
  localparam int          SAU_BYTE_W   = 8;
  localparam logic [63:0] SAU_PC_STEP  = 64'h0000_0000_0000_0004;
  localparam logic [31:0] SAU_NONE     = 32'hFFFF_FFFF;
  localparam logic [31:0] SAU_ONE32    = 32'h0000_0001;
  localparam logic [63:0] SAU_ONE64    = 64'h0000_0000_0000_0001;
  localparam logic [63:0] SAU_MASK_RST = 64'h0000_0000_0000_0000;

  // ---------------------------------------------------------------
  // opcodes handled by this unit
  // ---------------------------------------------------------------
  localparam logic [5:0] SAU_OP_LZC32   = 6'h15;
  localparam logic [5:0] SAU_OP_LZC64   = 6'h16;
  localparam logic [5:0] SAU_OP_SRUN32  = 6'h17;
  localparam logic [5:0] SAU_OP_SRUN64  = 6'h18;
  localparam logic [5:0] SAU_OP_SEXT8   = 6'h19;
  localparam logic [5:0] SAU_OP_SEXT16  = 6'h1A;
  localparam logic [5:0] SAU_OP_BCLR32  = 6'h1B;
  localparam logic [5:0] SAU_OP_BCLR64  = 6'h1C;
  localparam logic [5:0] SAU_OP_BSET32  = 6'h1D;
  localparam logic [5:0] SAU_OP_BSET64  = 6'h1E;
  localparam logic [5:0] SAU_OP_GETPC   = 6'h1F;
  localparam logic [5:0] SAU_OP_SETPC   = 6'h20;
  localparam logic [5:0] SAU_OP_SWAPPC  = 6'h21;
  localparam logic [5:0] SAU_OP_RFE     = 6'h22;
  localparam logic [5:0] SAU_OP_MSK_AND = 6'h24;
  localparam logic [5:0] SAU_OP_MSK_OR  = 6'h25;
  localparam logic [5:0] SAU_OP_MSK_XOR = 6'h26;
  localparam logic [5:0] SAU_OP_MSK_ANI = 6'h27;
  localparam logic [5:0] SAU_OP_MSK_ORI = 6'h28;
  localparam logic [5:0] SAU_OP_MSK_NAN = 6'h29;
  localparam logic [5:0] SAU_OP_MSK_NOR = 6'h2A;

  // ---------------------------------------------------------------
  // register map (byte addresses) and fields
  // ---------------------------------------------------------------
  localparam int         SAU_AXI_AW      = 8;
  localparam logic [7:0] SAU_OFF_CTRL    = 8'h00;
  localparam logic [7:0] SAU_OFF_MASK_LO = 8'h04;
  localparam logic [7:0] SAU_OFF_MASK_HI = 8'h08;
  localparam logic [7:0] SAU_OFF_PC_LO   = 8'h0C;
  localparam logic [7:0] SAU_OFF_PC_HI   = 8'h10;
  localparam logic [7:0] SAU_OFF_OPCNT   = 8'h14;
  localparam int         SAU_CTRL_PRIVILEGE_FLAG   = 0;
  localparam int         SAU_CTRL_COND   = 1;
  localparam logic [1:0] SAU_RESP_OKAY   = 2'h0;
  localparam logic [1:0] SAU_RESP_SLVERR = 2'h2;

  // ---------------------------------------------------------------
  // carriers
  // ---------------------------------------------------------------
  typedef struct packed {
    logic [5:0]  op;
    logic [63:0] pc;
    logic [63:0] src;
    logic [63:0] dstOld;
  } sau_issue_t;

  typedef struct packed {
    logic        write;
    logic        wide;
    logic [63:0] data;
  } sau_result_t;

endpackage

// File: core/sau_bit_scan.sv
// bit scanner: leading-zero and sign-run counts for 32 and 64 bit sources
module sau_bit_scan (
  input  wire logic [63:0] src,
  output logic      [31:0] lead32,
  output logic      [31:0] lead64,
  output logic      [31:0] run32,
  output logic      [31:0] run64
);

  // ---------------------------------------------------------------
  // per-bit scan vectors, index 0 is the msb side
  // ---------------------------------------------------------------
  logic [63:0] hit64;
  logic [63:0] dif64;
  logic [31:0] hit32;
  logic [31:0] dif32;

  // dif vectors compare each bit against the sign, so index 0 is always clear
  for (genvar i = 0; i < 64; i++) begin : g_bit
    assign hit64[i] = src[63-i];
    assign dif64[i] = src[63-i] ^ src[63];
    if (i < 32) begin : g_low
      assign hit32[i] = src[31-i];
      assign dif32[i] = src[31-i] ^ src[31];
    end
  end

  // priority scan: walking downward lets the lowest index win
  always_comb begin
    lead32 = sau_pkg::SAU_NONE;
    lead64 = sau_pkg::SAU_NONE;
    run32  = sau_pkg::SAU_NONE;
    run64  = sau_pkg::SAU_NONE;
    for (int i = 63; i >= 0; i--) begin
      if (hit64[i]) lead64 = 32'(i);
      if (dif64[i]) run64 = 32'(i);
    end
    for (int i = 31; i >= 0; i--) begin
      if (hit32[i]) lead32 = 32'(i);
      if (dif32[i]) run32 = 32'(i);
    end
  end

endmodule // sau_bit_scan

// File: core/sau_unary_alu.sv
// scalar unary alu: counts, extends, bit ops, pc ops and lane-mask saves
// Notes on behaviour
// - leading-zero count from msb, none gives all ones
// - sign-run index below msb, none gives -1
// - byte sign-extend from bit 7
// - halfword sign-extend from bit 15
// - bit clear indexed by source bits 4:0/5:0
// - bit set indexed by source bits 4:0/5:0
// - read pc returns pc plus 4
// - load pc from 64-bit source
// - swap returns pc plus 4, loads source
// - return clears privilege, loads pc
// - mask saves return old mask, flag nonzero
// - and variant: source and old mask
// - or variant: source or old mask
// - xor variant: source xor old mask
// - and-inverted: source and not old mask
// - or-inverted: source or not old mask
// - nand variant: inverse of source and mask
// - nor variant: inverse of source or mask
//
// The register offsets and register access over AXI4-Lite were decided locally.
module sau_unary_alu (
  input  wire logic                 clk_sys,
  input  wire logic                 reset_n,
  input  wire logic                 ce,
  input  wire logic                 issueValid,
  input  wire sau_pkg::sau_issue_t  issue,
  output sau_pkg::sau_result_t      result,
  output logic               [63:0] laneMask,
  output logic                      condFlag,
  output logic                      privFlag,
  output logic                      pcLoad,
  output logic               [63:0] pcTarget,
  output logic                      opError,
  input  wire logic                 s_axi_awvalid,
  output logic                      s_axi_awready,
  input  wire logic           [7:0] s_axi_awaddr,
  input  wire logic                 s_axi_wvalid,
  output logic                      s_axi_wready,
  input  wire logic          [31:0] s_axi_wdata,
  input  wire logic           [3:0] s_axi_wstrb,
  output logic                      s_axi_bvalid,
  input  wire logic                 s_axi_bready,
  output logic                [1:0] s_axi_bresp,
  input  wire logic                 s_axi_arvalid,
  output logic                      s_axi_arready,
  input  wire logic           [7:0] s_axi_araddr,
  output logic                      s_axi_rvalid,
  input  wire logic                 s_axi_rready,
  output logic               [31:0] s_axi_rdata,
  output logic                [1:0] s_axi_rresp
);

  // ---------------------------------------------------------------
  // declarations
  // ---------------------------------------------------------------
  sau_pkg::sau_result_t resQ, resD;
  logic [63:0] maskQ, maskD, maskNew;
  logic        condQ, condD, privQ, privD;
  logic        pcLoadQ, pcLoadD, errQ, errD;
  logic [63:0] pcTgtQ, pcTgtD;
  logic [31:0] cntQ, cntD;
  logic [31:0] lead32, lead64, run32, run64;
  logic        awHeldQ, awHeldD, wHeldQ, wHeldD;
  logic [7:0]  awAddrQ, awAddrD;
  logic [31:0] wDataQ, wDataD;
  logic [3:0]  wStrbQ, wStrbD;
  logic        bValidQ, bValidD, awRdyQ, awRdyD, wRdyQ, wRdyD;
  logic [1:0]  bRespQ, bRespD;
  logic        wrDo;
  logic        arRdyQ, arRdyD, rValidQ, rValidD;
  logic [31:0] rDataQ, rDataD;
  logic [1:0]  rRespQ, rRespD;

  // byte-lane merge for software writes
  function automatic logic [31:0] sauMerge(input logic [31:0] old, input logic [31:0] wd,
                                           input logic [3:0] st);
    logic [31:0] r;
    r = old;
    for (int b = 0; b < 4; b++) begin
      if (st[b]) r[b*sau_pkg::SAU_BYTE_W +: sau_pkg::SAU_BYTE_W] =
          wd[b*sau_pkg::SAU_BYTE_W +: sau_pkg::SAU_BYTE_W];
    end
    return r;
  endfunction

  sau_bit_scan u_scan (
    .src    (issue.src),
    .lead32 (lead32),
    .lead64 (lead64),
    .run32  (run32),
    .run64  (run64)
  );

  // ---------------------------------------------------------------
  // lane mask combine
  // ---------------------------------------------------------------
  // new mask for whichever save variant is issued
  always_comb begin
    case (issue.op)
      sau_pkg::SAU_OP_MSK_AND: maskNew = issue.src & maskQ;
      sau_pkg::SAU_OP_MSK_OR:  maskNew = issue.src | maskQ;
      sau_pkg::SAU_OP_MSK_XOR: maskNew = issue.src ^ maskQ;
      sau_pkg::SAU_OP_MSK_ANI: maskNew = issue.src & ~maskQ;
      sau_pkg::SAU_OP_MSK_ORI: maskNew = issue.src | ~maskQ;
      sau_pkg::SAU_OP_MSK_NAN: maskNew = ~(issue.src & maskQ);
      sau_pkg::SAU_OP_MSK_NOR: maskNew = ~(issue.src | maskQ);
      default:                 maskNew = maskQ;
    endcase
  end

  // ---------------------------------------------------------------
  // datapath
  // ---------------------------------------------------------------
  // software writes apply first; a mask save or return issued in the same cycle overrides them
  always_comb begin
    resD    = '0;
    maskD   = maskQ;
    condD   = condQ;
    privD   = privQ;
    pcLoadD = 1'b0;
    pcTgtD  = pcTgtQ;
    errD    = 1'b0;
    cntD    = cntQ;
    if (wrDo && awAddrQ == sau_pkg::SAU_OFF_CTRL && wStrbQ[0]) privD = wDataQ[sau_pkg::SAU_CTRL_PRIVILEGE_FLAG];
    if (wrDo && awAddrQ == sau_pkg::SAU_OFF_MASK_LO) maskD[31:0] = sauMerge(maskQ[31:0], wDataQ, wStrbQ);
    if (wrDo && awAddrQ == sau_pkg::SAU_OFF_MASK_HI) maskD[63:32] = sauMerge(maskQ[63:32], wDataQ, wStrbQ);
    if (issueValid) begin
      cntD      = cntQ + sau_pkg::SAU_ONE32;
      resD.write = 1'b1;
      case (issue.op)
        sau_pkg::SAU_OP_LZC32:  resD.data[31:0] = lead32;
        sau_pkg::SAU_OP_LZC64:  resD.data[31:0] = lead64;
        sau_pkg::SAU_OP_SRUN32: resD.data[31:0] = run32;
        sau_pkg::SAU_OP_SRUN64: resD.data[31:0] = run64;
        sau_pkg::SAU_OP_SEXT8:  resD.data[31:0] = {{24{issue.src[7]}}, issue.src[7:0]};
        sau_pkg::SAU_OP_SEXT16: resD.data[31:0] = {{16{issue.src[15]}}, issue.src[15:0]};
        sau_pkg::SAU_OP_BCLR32:
          resD.data[31:0] = issue.dstOld[31:0] & ~(sau_pkg::SAU_ONE32 << issue.src[4:0]);
        sau_pkg::SAU_OP_BSET32:
          resD.data[31:0] = issue.dstOld[31:0] | (sau_pkg::SAU_ONE32 << issue.src[4:0]);
        sau_pkg::SAU_OP_BCLR64: begin
          resD.wide = 1'b1;
          resD.data = issue.dstOld & ~(sau_pkg::SAU_ONE64 << issue.src[5:0]);
        end
        sau_pkg::SAU_OP_BSET64: begin
          resD.wide = 1'b1;
          resD.data = issue.dstOld | (sau_pkg::SAU_ONE64 << issue.src[5:0]);
        end
        sau_pkg::SAU_OP_GETPC: begin
          resD.wide = 1'b1;
          resD.data = issue.pc + sau_pkg::SAU_PC_STEP;
        end
        sau_pkg::SAU_OP_SETPC: begin
          resD.write = 1'b0;
          pcLoadD    = 1'b1;
          pcTgtD     = issue.src;
        end
        sau_pkg::SAU_OP_SWAPPC: begin
          resD.wide = 1'b1;
          resD.data = issue.pc + sau_pkg::SAU_PC_STEP;
          pcLoadD   = 1'b1;
          pcTgtD    = issue.src;
        end
        sau_pkg::SAU_OP_RFE: begin
          // the issuer only sends this from a trap handler, so no privilege check here
          resD.write = 1'b0;
          privD      = 1'b0;
          pcLoadD    = 1'b1;
          pcTgtD     = issue.src;
        end
        sau_pkg::SAU_OP_MSK_AND, sau_pkg::SAU_OP_MSK_OR, sau_pkg::SAU_OP_MSK_XOR,
        sau_pkg::SAU_OP_MSK_ANI, sau_pkg::SAU_OP_MSK_ORI, sau_pkg::SAU_OP_MSK_NAN,
        sau_pkg::SAU_OP_MSK_NOR: begin
          resD.wide = 1'b1;
          resD.data = maskQ;
          maskD     = maskNew;
          condD     = (maskNew != '0);
        end
        default: begin
          // foreign opcodes are flagged and not counted
          resD.write = 1'b0;
          errD       = 1'b1;
          cntD       = cntQ;
        end
      endcase
    end
  end

  // datapath state; ce low freezes everything
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      resQ    <= '0;
      maskQ   <= sau_pkg::SAU_MASK_RST;
      condQ   <= 1'b0;
      privQ   <= 1'b0;
      pcLoadQ <= 1'b0;
      pcTgtQ  <= '0;
      errQ    <= 1'b0;
      cntQ    <= '0;
    end else if (ce) begin
      resQ    <= resD;
      maskQ   <= maskD;
      condQ   <= condD;
      privQ   <= privD;
      pcLoadQ <= pcLoadD;
      pcTgtQ  <= pcTgtD;
      errQ    <= errD;
      cntQ    <= cntD;
    end
  end

  assign result   = resQ;
  assign laneMask = maskQ;
  assign condFlag = condQ;
  assign privFlag = privQ;
  assign pcLoad   = pcLoadQ;
  assign pcTarget = pcTgtQ;
  assign opError  = errQ;

  // ---------------------------------------------------------------
  // register bus: write channel
  // ---------------------------------------------------------------
  // address and data are held until both are in, then committed one cycle later
  always_comb begin
    wrDo    = awHeldQ && wHeldQ && !bValidQ;
    awHeldD = awHeldQ | (s_axi_awvalid && awRdyQ);
    wHeldD  = wHeldQ | (s_axi_wvalid && wRdyQ);
    awAddrD = (s_axi_awvalid && awRdyQ) ? s_axi_awaddr : awAddrQ;
    wDataD  = (s_axi_wvalid && wRdyQ) ? s_axi_wdata : wDataQ;
    wStrbD  = (s_axi_wvalid && wRdyQ) ? s_axi_wstrb : wStrbQ;
    bValidD = bValidQ && !s_axi_bready;
    bRespD  = bRespQ;
    if (wrDo) begin
      awHeldD = 1'b0;
      wHeldD  = 1'b0;
      bValidD = 1'b1;
      bRespD  = (awAddrQ == sau_pkg::SAU_OFF_CTRL || awAddrQ == sau_pkg::SAU_OFF_MASK_LO ||
                 awAddrQ == sau_pkg::SAU_OFF_MASK_HI || awAddrQ == sau_pkg::SAU_OFF_PC_LO ||
                 awAddrQ == sau_pkg::SAU_OFF_PC_HI || awAddrQ == sau_pkg::SAU_OFF_OPCNT) ?
                sau_pkg::SAU_RESP_OKAY : sau_pkg::SAU_RESP_SLVERR;
    end
    awRdyD = !awHeldD && !bValidD;
    wRdyD  = !wHeldD && !bValidD;
  end

  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      awHeldQ <= 1'b0;
      wHeldQ  <= 1'b0;
      awAddrQ <= '0;
      wDataQ  <= '0;
      wStrbQ  <= '0;
      bValidQ <= 1'b0;
      bRespQ  <= sau_pkg::SAU_RESP_OKAY;
      awRdyQ  <= 1'b0;
      wRdyQ   <= 1'b0;
    end else if (ce) begin
      awHeldQ <= awHeldD;
      wHeldQ  <= wHeldD;
      awAddrQ <= awAddrD;
      wDataQ  <= wDataD;
      wStrbQ  <= wStrbD;
      bValidQ <= bValidD;
      bRespQ  <= bRespD;
      awRdyQ  <= awRdyD;
      wRdyQ   <= wRdyD;
    end
  end

  assign s_axi_awready = awRdyQ;
  assign s_axi_wready  = wRdyQ;
  assign s_axi_bvalid  = bValidQ;
  assign s_axi_bresp   = bRespQ;

  // ---------------------------------------------------------------
  // register bus: read channel
  // ---------------------------------------------------------------
  // reads see state as of the address handshake; unmapped reads give zero and an error
  always_comb begin
    rValidD = rValidQ && !s_axi_rready;
    rDataD  = rDataQ;
    rRespD  = rRespQ;
    if (s_axi_arvalid && arRdyQ) begin
      rValidD = 1'b1;
      rDataD  = '0;
      rRespD  = sau_pkg::SAU_RESP_OKAY;
      case (s_axi_araddr)
        sau_pkg::SAU_OFF_CTRL: begin
          rDataD[sau_pkg::SAU_CTRL_PRIVILEGE_FLAG] = privQ;
          rDataD[sau_pkg::SAU_CTRL_COND] = condQ;
        end
        sau_pkg::SAU_OFF_MASK_LO: rDataD = maskQ[31:0];
        sau_pkg::SAU_OFF_MASK_HI: rDataD = maskQ[63:32];
        sau_pkg::SAU_OFF_PC_LO:   rDataD = pcTgtQ[31:0];
        sau_pkg::SAU_OFF_PC_HI:   rDataD = pcTgtQ[63:32];
        sau_pkg::SAU_OFF_OPCNT:   rDataD = cntQ;
        default:                  rRespD = sau_pkg::SAU_RESP_SLVERR;
      endcase
    end
    arRdyD = !rValidD;
  end

  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      arRdyQ  <= 1'b0;
      rValidQ <= 1'b0;
      rDataQ  <= '0;
      rRespQ  <= sau_pkg::SAU_RESP_OKAY;
    end else if (ce) begin
      arRdyQ  <= arRdyD;
      rValidQ <= rValidD;
      rDataQ  <= rDataD;
      rRespQ  <= rRespD;
    end
  end

  assign s_axi_arready = arRdyQ;
  assign s_axi_rvalid  = rValidQ;
  assign s_axi_rdata   = rDataQ;
  assign s_axi_rresp   = rRespQ;

  // ---------------------------------------------------------------
  // assertions
  // ---------------------------------------------------------------
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!reset_n);

  logic go;
  assign go = ce && issueValid;

  a_lzc_empty: assert property (go && issue.op == sau_pkg::SAU_OP_LZC32 && issue.src[31:0] == '0
    |=> result.write && result.data[31:0] == 32'hFFFF_FFFF) else $error("lzc of zero not all ones");
  a_lzc_index: assert property (go && issue.op == sau_pkg::SAU_OP_LZC64 && issue.src[63:61] == 3'h1
    |=> result.data[31:0] == 32'h0000_0002) else $error("lzc64 index wrong");
  a_srun_index: assert property (go && issue.op == sau_pkg::SAU_OP_SRUN32 && issue.src[31] != issue.src[30]
    |=> result.data[31:0] == 32'h0000_0001) else $error("sign run index wrong");
  a_srun_flat: assert property (go && issue.op == sau_pkg::SAU_OP_SRUN64 && (&issue.src || issue.src == '0)
    |=> result.data[31:0] == 32'hFFFF_FFFF) else $error("flat sign run not -1");
  a_sext_byte: assert property (go && issue.op == sau_pkg::SAU_OP_SEXT8
    |=> result.data[31:8] == {24{$past(issue.src[7])}}) else $error("byte extend wrong");
  a_sext_half: assert property (go && issue.op == sau_pkg::SAU_OP_SEXT16
    |=> result.data[31:0] == {{16{$past(issue.src[15])}}, $past(issue.src[15:0])}) else $error("half extend wrong");
  a_bit_clear: assert property (go && issue.op == sau_pkg::SAU_OP_BCLR64
    |=> result.data == ($past(issue.dstOld) & ~(sau_pkg::SAU_ONE64 << $past(issue.src[5:0]))))
    else $error("bit clear wrong");
  a_bit_keep: assert property (go && issue.op == sau_pkg::SAU_OP_BSET32
    |=> result.data[31:0] == ($past(issue.dstOld[31:0]) | (sau_pkg::SAU_ONE32 << $past(issue.src[4:0]))))
    else $error("bit set disturbed others");
  a_getpc_next: assert property (go && issue.op == sau_pkg::SAU_OP_GETPC
    |=> result.wide && result.data == $past(issue.pc) + sau_pkg::SAU_PC_STEP) else $error("getpc wrong");
  a_setpc_jump: assert property (go && issue.op == sau_pkg::SAU_OP_SETPC
    |=> pcLoad && !result.write && pcTarget == $past(issue.src) ##1 (!pcLoad || $past(go) || !$past(ce)))
    else $error("setpc wrong");
  a_swap_both: assert property (go && issue.op == sau_pkg::SAU_OP_SWAPPC
    |=> pcLoad && pcTarget == $past(issue.src) && result.data == $past(issue.pc) + sau_pkg::SAU_PC_STEP)
    else $error("swap wrong");
  a_rfe_drop: assert property (go && issue.op == sau_pkg::SAU_OP_RFE
    |=> !privFlag && pcLoad && pcTarget == $past(issue.src)) else $error("rfe wrong");
  a_mask_save: assert property (go && issue.op == sau_pkg::SAU_OP_MSK_XOR
    |=> result.data == $past(laneMask) && laneMask == ($past(issue.src) ^ $past(laneMask))
        && condFlag == (laneMask != '0)) else $error("mask save wrong");

  c_lzc_empty: cover property (go && issue.op == sau_pkg::SAU_OP_LZC32 && issue.src[31:0] == '0);
  c_swap_pc: cover property (go && issue.op == sau_pkg::SAU_OP_SWAPPC);
  c_mask_zero: cover property (go && issue.op == sau_pkg::SAU_OP_MSK_NOR ##1 !condFlag);
  c_axi_write: cover property (s_axi_bvalid && s_axi_bready);

endmodule // sau_unary_alu

// File: test/sau_issuer_model.sv
// partner model: instruction sequencer that issues scalar ops to the alu
module sau_issuer_model (
  input  wire logic          clk_sys,
  input  wire logic          trapActive,
  output logic               issueValid,
  output sau_pkg::sau_issue_t issue
);
  timeunit 1ns;
  timeprecision 1ps;

  // idle operands at time zero
  initial begin
    issueValid = 1'b0;
    issue = '0;
  end

  // one op per call, driven after the next edge and taken at the edge after it; a return outside a trap is never sent
  task automatic send(input logic [5:0] op, input logic [63:0] pc, src, dst);
    if (op == sau_pkg::SAU_OP_RFE && !trapActive) return;
    @(posedge clk_sys);
    issueValid <= 1'b1;
    issue <= '{op: op, pc: pc, src: src, dstOld: dst};
    @(posedge clk_sys);
    issueValid <= 1'b0;
    issue.src <= ~src; // stale operand is not left standing
    #1;
  endtask
endmodule // sau_issuer_model

// File: test/sau_unary_alu_tb_top.sv
// testbench: issues ops and speaks axi4-lite to the scalar unary alu
module sau_unary_alu_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic                 clk_sys = 1'b0;
  logic                 reset_n = 1'b0;
  logic                 ce = 1'b1;
  logic                 trapActive = 1'b0;
  logic                 issueValid, condFlag, privFlag, pcLoad, opError;
  sau_pkg::sau_issue_t  issue;
  sau_pkg::sau_result_t result;
  logic [63:0]          laneMask, pcTarget;
  logic                 awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
  logic                 awready, wready, bvalid, arready, rvalid;
  logic [7:0]           awaddr = 0, araddr = 0;
  logic [31:0]          wdata = 0, rdata;
  logic [1:0]           bresp, rresp;
  int                   errTotal = 0;
  int                   samplesChecked = 0;
  int                   cycles = 0;

  sau_issuer_model partner (.clk_sys(clk_sys), .trapActive(trapActive), .issueValid(issueValid), .issue(issue));
  sau_unary_alu dut (.clk_sys(clk_sys), .reset_n(reset_n), .ce(ce), .issueValid(issueValid), .issue(issue),
    .result(result), .laneMask(laneMask), .condFlag(condFlag), .privFlag(privFlag), .pcLoad(pcLoad),
    .pcTarget(pcTarget), .opError(opError), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_awaddr(awaddr), .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_wdata(wdata),
    .s_axi_wstrb(4'hF), .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_bresp(bresp),
    .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_araddr(araddr), .s_axi_rvalid(rvalid),
    .s_axi_rready(rready), .s_axi_rdata(rdata), .s_axi_rresp(rresp));

  // ---------------------------------------------------------------
  // clock, hang guard and shared tasks
  // ---------------------------------------------------------------
  always #10 clk_sys = ~clk_sys;

  // a hung handshake would otherwise stall the run forever
  always @(posedge clk_sys) begin
    cycles++;
    if (cycles == 5000) begin
      errTotal++;
      giveVerdict();
    end
  end

  task automatic giveVerdict();
    $display("checked %0d mismatches %0d", samplesChecked, errTotal);
    if (errTotal == 0 && samplesChecked > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask

  task automatic chk(input logic [63:0] seen, exp);
    samplesChecked++;
    if (seen !== exp) begin
      errTotal++;
      $display("unexpected at %0t: saw %h want %h", $time, seen, exp);
    end
  endtask

  // each channel is released at the edge where its ready is seen
  task automatic axiWr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
    @(posedge clk_sys);
    awvalid <= 1'b1;
    awaddr <= a;
    wvalid <= 1'b1;
    wdata <= d;
    bready <= 1'b1;
    forever begin
      @(posedge clk_sys);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
      if (bvalid) begin
        r = bresp;
        bready <= 1'b0;
        break;
      end
    end
  endtask

  task automatic axiRd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    @(posedge clk_sys);
    arvalid <= 1'b1;
    araddr <= a;
    rready <= 1'b1;
    forever begin
      @(posedge clk_sys);
      if (arready) arvalid <= 1'b0;
      if (rvalid) begin
        d = rdata;
        r = rresp;
        rready <= 1'b0;
        break;
      end
    end
  endtask

  // issue one op and check the written destination
  task automatic run(input logic [5:0] op, input logic [63:0] pc, src, dst, exp, input logic wide);
    partner.send(op, pc, src, dst);
    chk({result.write, result.wide}, {1'b1, wide});
    chk(result.data, exp);
  endtask

  function automatic logic [63:0] newMask(input logic [5:0] op, input logic [63:0] s, o);
    case (op)
      sau_pkg::SAU_OP_MSK_AND: return s & o;
      sau_pkg::SAU_OP_MSK_OR:  return s | o;
      sau_pkg::SAU_OP_MSK_XOR: return s ^ o;
      sau_pkg::SAU_OP_MSK_ANI: return s & ~o;
      sau_pkg::SAU_OP_MSK_ORI: return s | ~o;
      sau_pkg::SAU_OP_MSK_NAN: return ~(s & o);
      default:                 return ~(s | o);
    endcase
  endfunction

  // ---------------------------------------------------------------
  // test sequence
  // ---------------------------------------------------------------
  initial begin
    logic [31:0] d;
    logic [1:0]  r;
    logic [63:0] m, nm, s;
    logic [5:0]  ops[8];
    ops = '{6'h24, 6'h25, 6'h26, 6'h27, 6'h28, 6'h29, 6'h2A, 6'h24};
    repeat (16) @(posedge clk_sys);
    reset_n <= 1'b1;
    axiRd(sau_pkg::SAU_OFF_MASK_LO, d, r);
    chk(d, 0);
    axiWr(sau_pkg::SAU_OFF_MASK_LO, 32'hF0F0_00FF, r);
    axiWr(sau_pkg::SAU_OFF_MASK_HI, 32'h8000_0001, r);
    axiRd(sau_pkg::SAU_OFF_MASK_HI, d, r);
    chk(d, 32'h8000_0001);
    axiRd(8'h40, d, r);
    chk({r, d}, {sau_pkg::SAU_RESP_SLVERR, 32'h0});
    axiWr(8'h40, 32'h1, r);
    chk(r, sau_pkg::SAU_RESP_SLVERR);
    $display("test registers done");
    run(6'h15, 0, 64'h0, 0, 64'hFFFF_FFFF, 0);
    run(6'h15, 0, 64'h0000_CCCC, 0, 64'd16, 0);
    run(6'h15, 0, 64'h7FFF_FFFF, 0, 64'd1, 0);
    run(6'h16, 0, 64'h8000_0000, 0, 64'd32, 0);
    run(6'h16, 0, 64'h2000_0000_0000_0000, 0, 64'd2, 0);
    run(6'h16, 0, 64'h0, 0, 64'hFFFF_FFFF, 0);
    run(6'h17, 0, 64'hFFFF_3333, 0, 64'd16, 0);
    run(6'h17, 0, 64'h8000_0000, 0, 64'd1, 0);
    run(6'h17, 0, 64'hFFFF_FFFF, 0, 64'hFFFF_FFFF, 0);
    run(6'h18, 0, 64'hFFFF_FFFF_FFFF_0000, 0, 64'd48, 0);
    run(6'h18, 0, 64'h0, 0, 64'hFFFF_FFFF, 0);
    run(6'h19, 0, 64'h1234_5680, 0, 64'hFFFF_FF80, 0);
    run(6'h19, 0, 64'hFF7F, 0, 64'h7F, 0);
    run(6'h1A, 0, 64'h8001, 0, 64'hFFFF_8001, 0);
    run(6'h1A, 0, 64'hF_7FFF, 0, 64'h7FFF, 0);
    run(6'h1B, 0, 64'h3F, 64'hFFFF_FFFF, 64'h7FFF_FFFF, 0);
    run(6'h1C, 0, 64'h60, '1, 64'hFFFF_FFFE_FFFF_FFFF, 1);
    run(6'h1D, 0, 64'h21, 64'h1234_0000, 64'h1234_0002, 0);
    run(6'h1E, 0, 64'h7F, 64'h1, 64'h8000_0000_0000_0001, 1);
    $display("test counts and bits done");
    run(6'h1F, 64'h1_0000_1000, 0, 0, 64'h1_0000_1004, 1);
    partner.send(6'h20, 64'h10, 64'hABC0_0000_0040, 0);
    chk({pcLoad, result.write, pcTarget}, {2'b10, 64'hABC0_0000_0040});
    run(6'h21, 64'h2000, 64'h3000, 0, 64'h2004, 1);
    chk({pcLoad, pcTarget}, {1'b1, 64'h3000});
    axiWr(sau_pkg::SAU_OFF_CTRL, 32'h1, r);
    chk(privFlag, 1);
    trapActive = 1'b1;
    partner.send(6'h22, 0, 64'h400, 0);
    chk({privFlag, pcLoad, pcTarget}, {2'b01, 64'h400});
    partner.send(6'h23, 0, 0, 0);
    chk({opError, result.write}, 2'b10);
    @(posedge clk_sys);
    ce <= 1'b0;
    partner.send(6'h20, 0, 64'h999, 0);
    chk({pcLoad, pcTarget}, {1'b0, 64'h400});
    @(posedge clk_sys);
    ce <= 1'b1;
    $display("test program counter done");
    m = 64'h8000_0001_F0F0_00FF;
    for (int i = 0; i < 8; i++) begin
      s = (i == 0) ? 64'h0 : 64'h0F0F_0000_FFFF_1234;
      nm = newMask(ops[i], s, m);
      run(ops[i], 0, s, 0, m, 1);
      chk(laneMask, nm);
      chk(condFlag, nm != 0);
      m = nm;
    end
    $display("test lane mask done");
    axiRd(sau_pkg::SAU_OFF_OPCNT, d, r);
    chk(d, 32'h0000_001F);
    axiRd(sau_pkg::SAU_OFF_PC_LO, d, r);
    chk(d, 32'h0000_0400);
    $display("test status registers done");
    giveVerdict();
  end
endmodule // sau_unary_alu_tb_top
